/* rtl/uemc_regs.vh */
// register indices, field positions, codes and reset values
`ifndef UEMC_REGS_VH
`define UEMC_REGS_VH

// register indices; byte address on the bus is four times the index
`define UEMC_IDX_ADDR 8'h10
`define UEMC_IDX_CNT0 8'h11
`define UEMC_IDX_MODE0 8'h12
`define UEMC_IDX_CNT1 8'h13
`define UEMC_IDX_MODE1 8'h14
`define UEMC_IDX_CNT2 8'h15
`define UEMC_IDX_MODE2 8'h16

// endpoint buffer windows (indices, one byte per word)
`define UEMC_BUF_LO 8'hE8
`define UEMC_BUF_HI 8'hFF
`define UEMC_BUF0_LO 8'hF8
`define UEMC_BUF1_LO 8'hF0
`define UEMC_BUF2_LO 8'hE8
`define UEMC_BUF0_SLOT 5'h10

// field positions
`define UEMC_ADDR_EN 7
`define UEMC_MODE_SETUP 7
`define UEMC_MODE_STALL 7
`define UEMC_MODE_IN 6
`define UEMC_MODE_OUT 5
`define UEMC_MODE_ACKED 4
`define UEMC_CNT_TOGGLE 7
`define UEMC_CNT_VALID 6

// mode codes
`define UEMC_MODE_NAKALL 4'h1
`define UEMC_MODE_ACKOUT_NAKIN 4'hB
`define UEMC_MODE_ACKIN 4'hF

// token kinds from the protocol engine
`define UEMC_KIND_SETUP 2'h1
`define UEMC_KIND_IN 2'h2
`define UEMC_KIND_OUT 2'h3

// handshake answers to the protocol engine
`define UEMC_RESP_NONE 2'h0
`define UEMC_RESP_ACK 2'h1
`define UEMC_RESP_NAK 2'h2
`define UEMC_RESP_STALL 2'h3

// reset values and count offset
`define UEMC_RST_BYTE 8'h00
`define UEMC_CRC_BYTES 4'h2

`endif

/* rtl/uemc_top.v */
// endpoint mode, counter and address registers of a low-speed usb function
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "uemc_regs.vh"

module uemc_top (
    input wire clk,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire bus_reset,
    output reg addr_en,
    output reg [6:0] dev_addr,
    input wire tok_valid,
    input wire [6:0] tok_addr,
    input wire [1:0] tok_ep,
    input wire [1:0] tok_kind,
    output reg resp_valid,
    output reg [1:0] resp_code,
    input wire setup_start,
    input wire ack_start,
    input wire td_valid,
    input wire [1:0] td_ep,
    input wire [1:0] td_kind,
    input wire td_acked,
    input wire td_toggle,
    input wire td_err,
    input wire [3:0] td_bytes,
    input wire ebuf_wr,
    input wire [4:0] ebuf_addr,
    input wire [7:0] ebuf_wdata,
    input wire [4:0] ebuf_raddr,
    output reg [7:0] ebuf_rdata,
    output wire [23:0] ep_cnt
);

// ----------------------------------------------------------------
// apb access timing
// ----------------------------------------------------------------
wire acc = psel & penable;
// one wait state; effects happen only at the completing edge
wire done = acc & pready;
wire wr_done = done & pwrite;
wire rd_done = done & ~pwrite;
wire [9:0] widx = paddr[11:2];
wire aligned = (paddr[1:0] == 2'b00);
wire [7:0] idx = widx[7:0];
wire idx_ok = aligned & (widx[9:8] == 2'b00);

// ----------------------------------------------------------------
// address decode
// ----------------------------------------------------------------
wire sel_addr = idx_ok & (idx == `UEMC_IDX_ADDR);
wire [2:0] sel_cnt;
wire [2:0] sel_mode;
// ascending counter order: control, first, second
assign sel_cnt[0] = idx_ok & (idx == `UEMC_IDX_CNT0);
assign sel_cnt[1] = idx_ok & (idx == `UEMC_IDX_CNT1);
assign sel_cnt[2] = idx_ok & (idx == `UEMC_IDX_CNT2);
assign sel_mode[0] = idx_ok & (idx == `UEMC_IDX_MODE0);
assign sel_mode[1] = idx_ok & (idx == `UEMC_IDX_MODE1);
assign sel_mode[2] = idx_ok & (idx == `UEMC_IDX_MODE2);
wire sel_buf = idx_ok & (idx >= `UEMC_BUF_LO);
// buffer slot: 0..7 second, 8..15 first, 16..23 control
wire [7:0] buf_off = idx - `UEMC_BUF_LO;
wire [4:0] cpu_slot = buf_off[4:0];
wire mapped = sel_addr | (|sel_cnt) | (|sel_mode) | sel_buf;

// ----------------------------------------------------------------
// device address register
// ----------------------------------------------------------------
reg [7:0] addr_q;
reg [7:0] addr_d;

// bus reset clears the enable too, so the engine falls silent
always @* begin
    addr_d = addr_q;
    if (wr_done & sel_addr) begin
        addr_d = pwdata[7:0];
    end
    if (bus_reset) begin
        addr_d = `UEMC_RST_BYTE;
    end
end

always @(posedge clk) begin
    if (sys_rst) begin
        addr_q <= `UEMC_RST_BYTE;
        addr_en <= 1'b0;
        dev_addr <= 7'h00;
    end else begin
        addr_q <= addr_d;
        addr_en <= addr_d[`UEMC_ADDR_EN];
        dev_addr <= addr_d[6:0];
    end
end

// ----------------------------------------------------------------
// setup hold window on the control endpoint
// ----------------------------------------------------------------
reg hold_q;

// open at setup data start, closed at start of our ack
always @(posedge clk) begin
    if (sys_rst) begin
        hold_q <= 1'b0;
    end else begin
        hold_q <= setup_start | (hold_q & ~ack_start);
    end
end

// ----------------------------------------------------------------
// per endpoint mode and counter registers
// ----------------------------------------------------------------
wire [23:0] mode_all;
wire [3:0] cnt_rx = td_bytes + `UEMC_CRC_BYTES;

genvar g;
generate
for (g = 0; g < 3; g = g + 1) begin : ep
    localparam integer EPI = g;
    localparam [1:0] EPN = EPI[1:0];
    localparam IS_CTRL = (g == 0);
    reg [7:0] mode_q;
    reg [7:0] mode_d;
    reg [7:0] cnt_q;
    reg [7:0] cnt_d;
    reg mlock_q;
    reg clock_q;
    // engine updates of the last cycle, seen while read data stands
    reg upd_q;
    reg rxu_q;
    wire hit = td_valid & (td_ep == EPN);
    wire rx = hit & ((td_kind == `UEMC_KIND_SETUP) |
        (td_kind == `UEMC_KIND_OUT));
    wire wr_m = wr_done & sel_mode[g];
    wire rd_m = rd_done & sel_mode[g];
    wire wr_c = wr_done & sel_cnt[g];
    wire rd_c = rd_done & sel_cnt[g];
    // only the control endpoint locks
    wire m_locked = IS_CTRL & mlock_q;
    wire c_locked = IS_CTRL & clock_q;
    // read data was taken a cycle early; an update since keeps the lock
    wire rel_m = rd_m & ~upd_q;
    wire rel_c = rd_c & ~rxu_q;

    // mode register: cpu write first, engine updates override
    always @* begin
        mode_d = mode_q;
        if (wr_m & ~m_locked) begin
            if (IS_CTRL) begin
                mode_d = {4'h0, pwdata[3:0]};
            end else begin
                // reserved bits stored as zero
                mode_d = {pwdata[7], 2'b00, mode_q[4],
                    pwdata[3:0]};
            end
        end
        // only an acked bit that the read returned is cleared
        if (rd_m & !IS_CTRL & prdata[`UEMC_MODE_ACKED]) begin
            mode_d[`UEMC_MODE_ACKED] = 1'b0;
        end
        if (hit & td_acked) begin
            mode_d[`UEMC_MODE_ACKED] = 1'b1;
        end
        if (hit & IS_CTRL & (td_kind == `UEMC_KIND_IN)) begin
            mode_d[`UEMC_MODE_IN] = 1'b1;
        end
        if (hit & IS_CTRL & (td_kind == `UEMC_KIND_OUT)) begin
            mode_d[`UEMC_MODE_OUT] = 1'b1;
        end
        // self return to nak-both after an acked out
        if (hit & td_acked & (td_kind == `UEMC_KIND_OUT) &
            (mode_q[3:0] == `UEMC_MODE_ACKOUT_NAKIN)) begin
            mode_d[3:0] = `UEMC_MODE_NAKALL;
        end
        // setup flag pinned high; a cpu clear cannot win
        if (IS_CTRL & (setup_start | hold_q)) begin
            mode_d[`UEMC_MODE_SETUP] = 1'b1;
        end
    end

    // counter register: received data beats a cpu write
    always @* begin
        cnt_d = cnt_q;
        if (wr_c & ~c_locked) begin
            cnt_d = {pwdata[7:6], 2'b00, pwdata[3:0]};
        end
        if (rx) begin
            cnt_d = {td_toggle, ~td_err, 2'b00, cnt_rx};
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            mode_q <= `UEMC_RST_BYTE;
            cnt_q <= `UEMC_RST_BYTE;
            mlock_q <= 1'b0;
            clock_q <= 1'b0;
            upd_q <= 1'b0;
            rxu_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            cnt_q <= cnt_d;
            upd_q <= hit;
            rxu_q <= rx;
            // a new engine update wins over the unlocking read
            mlock_q <= (IS_CTRL & hit) | (mlock_q & ~rel_m);
            clock_q <= (IS_CTRL & rx) | (clock_q & ~rel_c);
        end
    end

    assign mode_all[8*g +: 8] = mode_q;
    assign ep_cnt[8*g +: 8] = cnt_q;
end
endgenerate

// ----------------------------------------------------------------
// endpoint buffers, 24 bytes of flip-flops
// ----------------------------------------------------------------
reg [7:0] buf_q [0:23];
// cpu may not write control data while setup flag is up; reads still pass
wire setup_flag = mode_all[`UEMC_MODE_SETUP];
wire cpu_buf_ok = ~(setup_flag & (cpu_slot >= `UEMC_BUF0_SLOT));
wire cpu_buf_wr = wr_done & sel_buf & cpu_buf_ok;

// engine write wins a same-cycle collision: it cannot retry
always @(posedge clk) begin
    if (ebuf_wr & (ebuf_addr < 5'd24)) begin
        buf_q[ebuf_addr] <= ebuf_wdata;
    end else if (cpu_buf_wr) begin
        buf_q[cpu_slot] <= pwdata[7:0];
    end
end

// registered read port toward the engine
always @(posedge clk) begin
    if (sys_rst) begin
        ebuf_rdata <= `UEMC_RST_BYTE;
    end else if (ebuf_raddr < 5'd24) begin
        ebuf_rdata <= buf_q[ebuf_raddr];
    end else begin
        ebuf_rdata <= `UEMC_RST_BYTE;
    end
end

// ----------------------------------------------------------------
// handshake decision for incoming tokens
// ----------------------------------------------------------------
reg [7:0] tok_mode;
reg [1:0] resp_d;
reg tok_stall;
wire tok_hit = tok_valid & addr_en & (tok_addr == dev_addr) &
    (tok_ep != 2'b11);

always @* begin
    case (tok_ep)
        2'b00: tok_mode = mode_all[7:0];
        2'b01: tok_mode = mode_all[15:8];
        2'b10: tok_mode = mode_all[23:16];
        default: tok_mode = `UEMC_RST_BYTE;
    endcase
    // control endpoint bit 7 is the setup flag, not a stall
    tok_stall = (tok_ep != 2'b00) & tok_mode[`UEMC_MODE_STALL];
    resp_d = `UEMC_RESP_NONE;
    case (tok_kind)
        `UEMC_KIND_SETUP: begin
            resp_d = `UEMC_RESP_ACK;
        end
        `UEMC_KIND_IN: begin
            if (tok_mode[3:0] == `UEMC_MODE_ACKIN) begin
                resp_d = tok_stall ? `UEMC_RESP_STALL :
                    `UEMC_RESP_ACK;
            end else if ((tok_mode[3:0] == `UEMC_MODE_NAKALL) |
                (tok_mode[3:0] == `UEMC_MODE_ACKOUT_NAKIN)) begin
                resp_d = `UEMC_RESP_NAK;
            end
        end
        `UEMC_KIND_OUT: begin
            if (tok_mode[3:0] == `UEMC_MODE_ACKOUT_NAKIN) begin
                resp_d = tok_stall ? `UEMC_RESP_STALL :
                    `UEMC_RESP_ACK;
            end else if (tok_mode[3:0] == `UEMC_MODE_NAKALL) begin
                resp_d = `UEMC_RESP_NAK;
            end
        end
        default: begin
            resp_d = `UEMC_RESP_NONE;
        end
    endcase
end

always @(posedge clk) begin
    if (sys_rst) begin
        resp_valid <= 1'b0;
        resp_code <= `UEMC_RESP_NONE;
    end else begin
        resp_valid <= tok_hit;
        resp_code <= tok_hit ? resp_d : `UEMC_RESP_NONE;
    end
end

// ----------------------------------------------------------------
// apb read mux and answer
// ----------------------------------------------------------------
reg [7:0] rd_val;

always @* begin
    rd_val = `UEMC_RST_BYTE;
    if (sel_addr) begin
        rd_val = addr_q;
    end
    if (sel_cnt[0]) begin
        rd_val = ep_cnt[7:0];
    end
    if (sel_cnt[1]) begin
        rd_val = ep_cnt[15:8];
    end
    if (sel_cnt[2]) begin
        rd_val = ep_cnt[23:16];
    end
    if (sel_mode[0]) begin
        rd_val = mode_all[7:0];
    end
    if (sel_mode[1]) begin
        rd_val = mode_all[15:8];
    end
    if (sel_mode[2]) begin
        rd_val = mode_all[23:16];
    end
    if (sel_buf) begin
        rd_val = buf_q[cpu_slot];
    end
end

// read data is sampled one cycle early; side effects wait for done
always @(posedge clk) begin
    if (sys_rst) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
    end else begin
        pready <= acc & ~pready;
        pslverr <= acc & ~pready & ~mapped;
        if (acc & ~pready) begin
            prdata <= {24'h000000, mapped ? rd_val : 8'h00};
        end else begin
            prdata <= 32'h00000000;
        end
    end
end

endmodule

/* sim/uemc_chk_asserts.sv */
// port-level assertion checker for the endpoint register block
`timescale 1ns/1ps
`include "uemc_regs.vh"
module uemc_chk (
    input logic clk,
    input logic sys_rst,
    input logic psel,
    input logic penable,
    input logic pready,
    input logic pslverr,
    input logic bus_reset,
    input logic addr_en,
    input logic [6:0] dev_addr,
    input logic tok_valid,
    input logic [6:0] tok_addr,
    input logic [1:0] tok_ep,
    input logic [1:0] tok_kind,
    input logic resp_valid,
    input logic [1:0] resp_code,
    input logic td_valid,
    input logic [1:0] td_ep,
    input logic [1:0] td_kind,
    input logic td_toggle,
    input logic td_err,
    input logic [3:0] td_bytes,
    input logic [23:0] ep_cnt
);
    logic hit;
    // ---------------
    // checks
    // ---------------
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // token the engine must answer: enabled, own address, real endpoint
    assign hit = tok_valid && addr_en && tok_addr == dev_addr
        && tok_ep != 2'h3;
    a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready not after one wait state");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    a_resp_on_hit: assert property (hit |=> resp_valid)
        else $error("matching token not answered");
    a_resp_no_hit: assert property (!hit |=> !resp_valid)
        else $error("answer without matching token");
    a_resp_idle_code: assert property (!resp_valid |-> resp_code == 2'h0)
        else $error("answer code outside answer cycle");
    a_setup_acked: assert property
        (hit && tok_kind == `UEMC_KIND_SETUP |=> resp_code == `UEMC_RESP_ACK)
        else $error("setup token not acknowledged");
    a_bus_rst_clear: assert property
        (bus_reset |=> !addr_en && dev_addr == 7'h00)
        else $error("bus reset left address set");
    a_rx_count_load: assert property (td_valid && td_kind[0]
        && td_ep != 2'h3 |=> ep_cnt[8*$past(td_ep) +: 8] == {$past(td_toggle),
        !$past(td_err), 2'h0, $past(td_bytes) + `UEMC_CRC_BYTES})
        else $error("receive counter load wrong");
    // main scenarios reached
    cover property (resp_valid && resp_code == `UEMC_RESP_STALL);
    cover property (pready && pslverr);
    cover property (bus_reset ##1 !addr_en);
endmodule
bind uemc_top uemc_chk u_uemc_chk (.*);

/* sim/uemc_eng_model.sv */
// protocol engine stand-in driving tokens, transactions and buffer reads
`timescale 1ns/1ps
module uemc_eng_model (
    input logic clk,
    output logic bus_reset = 1'b0,
    output logic setup_start = 1'b0,
    output logic ack_start = 1'b0,
    output logic tok_valid = 1'b0,
    output logic [6:0] tok_addr = 7'h00,
    output logic [1:0] tok_ep = 2'h0,
    output logic [1:0] tok_kind = 2'h0,
    output logic td_valid = 1'b0,
    output logic [1:0] td_ep = 2'h0,
    output logic [1:0] td_kind = 2'h0,
    output logic td_acked = 1'b0,
    output logic td_toggle = 1'b0,
    output logic td_err = 1'b0,
    output logic [3:0] td_bytes = 4'h0,
    output logic ebuf_wr = 1'b0,
    output logic [4:0] ebuf_addr = 5'h00,
    output logic [7:0] ebuf_wdata = 8'h00,
    output logic [4:0] ebuf_raddr = 5'h00
);
    // ---------------
    // engine actions
    // ---------------
    // one-cycle event: 0 setup start, 1 ack start, 2 bus reset
    task pulse(input int w);
        @(posedge clk);
        {bus_reset, ack_start, setup_start} <= 3'h1 << w;
        @(posedge clk);
        {bus_reset, ack_start, setup_start} <= 3'h0;
    endtask
    // token; address flipped after release so stale matches cannot hide
    task tok(input logic [6:0] a, input logic [1:0] e, k);
        @(posedge clk);
        {tok_valid, tok_addr, tok_ep, tok_kind} <= {1'b1, a, e, k};
        @(posedge clk);
        tok_valid <= 1'b0;
        tok_addr <= ~a;
    endtask
    // finished transaction carrying the received toggle
    task td(input logic [1:0] e, k, input logic a, t, x, input logic [3:0] n);
        @(posedge clk);
        {td_valid, td_ep, td_kind, td_acked} <= {1'b1, e, k, a};
        {td_toggle, td_err, td_bytes} <= {t, x, n};
        @(posedge clk);
        td_valid <= 1'b0;
        td_bytes <= ~n;
    endtask
    // engine write of one buffer slot
    task wbuf(input logic [4:0] s, input logic [7:0] d);
        @(posedge clk);
        {ebuf_wr, ebuf_addr, ebuf_wdata} <= {1'b1, s, d};
        @(posedge clk);
        ebuf_wr <= 1'b0;
    endtask
    // engine-side buffer read address
    task rbuf(input logic [4:0] s);
        @(posedge clk);
        ebuf_raddr <= s;
        @(posedge clk);
    endtask
endmodule

/* sim/test_uemc_top.sv */
// self-checking bench for the endpoint register block
`timescale 1ns/1ps
`include "uemc_regs.vh"
module test_uemc_top;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd_q;
    logic pready, pslverr, addr_en, resp_valid, err_q;
    logic [6:0] dev_addr;
    logic [1:0] resp_code;
    logic [7:0] ebuf_rdata;
    logic [23:0] ep_cnt;
    wire bus_reset, setup_start, ack_start, tok_valid, td_valid, td_acked;
    wire td_toggle, td_err, ebuf_wr;
    wire [6:0] tok_addr;
    wire [1:0] tok_ep, tok_kind, td_ep, td_kind;
    wire [3:0] td_bytes;
    wire [4:0] ebuf_addr, ebuf_raddr;
    wire [7:0] ebuf_wdata;
    int miscompares = 0;
    int check_count = 0;
    uemc_top u_uemc_top (.*);
    uemc_eng_model u_uemc_eng_model (.*);
    // ---------------
    // helpers
    // ---------------
    always #2.5 clk = ~clk;
    task chk(input string n, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    // one apb transfer; held until pready is sampled high
    task apb(input logic w, input logic [9:0] i, input logic [7:0] d);
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, i, 2'h0, 24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        // no cycle count assumed; only the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task wr(input logic [9:0] i, input logic [7:0] d);
        apb(1'b1, i, d);
    endtask
    task rd(input string n, input logic [9:0] i, input logic [7:0] e);
        apb(1'b0, i, 8'h00);
        chk(n, rd_q, {24'h0, e});
    endtask
    task tokchk(input logic [6:0] a, input logic [1:0] e, k,
        input logic [2:0] x);
        u_uemc_eng_model.tok(a, e, k);
        @(posedge clk);
        chk("resp", {resp_valid, resp_code}, x);
    endtask
    task bufchk(input logic [4:0] s, input logic [7:0] e);
        u_uemc_eng_model.rbuf(s);
        @(posedge clk);
        chk("ebuf", ebuf_rdata, e);
    endtask
    // ---------------
    // scenarios
    // ---------------
    task t_reset;
        for (int i = 'h10; i <= 'h16; i++) rd("rst", i, 8'h00);
        rd("unmapped", 10'h020, 8'h00);
        chk("slverr", err_q, 1'b1);
    endtask
    task t_addr;
        wr(`UEMC_IDX_ADDR, 8'h85);
        @(posedge clk);
        chk("addr", {addr_en, dev_addr}, 8'h85);
        tokchk(7'h05, 2'h0, `UEMC_KIND_SETUP, 3'h5);
        tokchk(7'h06, 2'h0, `UEMC_KIND_SETUP, 3'h0);
        tokchk(7'h05, 2'h3, `UEMC_KIND_SETUP, 3'h0);
    endtask
    task t_modes;
        wr(`UEMC_IDX_MODE0, 8'h01);
        tokchk(7'h05, 2'h0, `UEMC_KIND_IN, 3'h6);
        tokchk(7'h05, 2'h0, `UEMC_KIND_OUT, 3'h6);
        wr(`UEMC_IDX_MODE1, 8'h8F);
        tokchk(7'h05, 2'h1, `UEMC_KIND_IN, 3'h7);
        wr(`UEMC_IDX_MODE1, 8'h0F);
        tokchk(7'h05, 2'h1, `UEMC_KIND_IN, 3'h5);
        wr(`UEMC_IDX_MODE2, 8'h0B);
        tokchk(7'h05, 2'h2, `UEMC_KIND_OUT, 3'h5);
        u_uemc_eng_model.td(2'h2, `UEMC_KIND_OUT, 1'b1, 1'b1, 1'b0, 4'h3);
        rd("mode2", `UEMC_IDX_MODE2, 8'h11);
        rd("mode2", `UEMC_IDX_MODE2, 8'h01);
        rd("cnt2", `UEMC_IDX_CNT2, 8'hC5);
        u_uemc_eng_model.td(2'h1, `UEMC_KIND_OUT, 1'b1, 1'b0, 1'b1, 4'h8);
        @(posedge clk);
        chk("cnt1", ep_cnt[15:8], 8'h0A);
    endtask
    task t_lock;
        wr(`UEMC_IDX_MODE0, 8'hFF);
        rd("mode0", `UEMC_IDX_MODE0, 8'h0F);
        u_uemc_eng_model.td(2'h0, `UEMC_KIND_IN, 1'b1, 1'b0, 1'b0, 4'h0);
        wr(`UEMC_IDX_MODE0, 8'h01);
        rd("mode0", `UEMC_IDX_MODE0, 8'h5F);
        wr(`UEMC_IDX_MODE0, 8'h03);
        rd("mode0", `UEMC_IDX_MODE0, 8'h03);
        u_uemc_eng_model.td(2'h0, `UEMC_KIND_OUT, 1'b1, 1'b1, 1'b0, 4'h0);
        wr(`UEMC_IDX_CNT0, 8'h05);
        rd("cnt0", `UEMC_IDX_CNT0, 8'hC2);
        wr(`UEMC_IDX_CNT0, 8'h05);
        rd("cnt0", `UEMC_IDX_CNT0, 8'h05);
        rd("mode0", `UEMC_IDX_MODE0, 8'h33);
    endtask
    task t_setup;
        wr(10'h0F8, 8'hA1);
        wr(10'h0F0, 8'hA2);
        wr(10'h0E8, 8'hA3);
        bufchk(5'h10, 8'hA1);
        bufchk(5'h08, 8'hA2);
        bufchk(5'h00, 8'hA3);
        u_uemc_eng_model.pulse(0);
        wr(`UEMC_IDX_MODE0, 8'h00);
        rd("mode0", `UEMC_IDX_MODE0, 8'h80);
        wr(10'h0F8, 8'h55);
        bufchk(5'h10, 8'hA1);
        u_uemc_eng_model.wbuf(5'h11, 8'h3C);
        bufchk(5'h11, 8'h3C);
        rd("buf0", 10'h0F9, 8'h3C);
        u_uemc_eng_model.pulse(1);
        wr(`UEMC_IDX_MODE0, 8'h00);
        rd("mode0", `UEMC_IDX_MODE0, 8'h00);
        wr(10'h0F8, 8'h55);
        bufchk(5'h10, 8'h55);
        u_uemc_eng_model.pulse(2);
        @(posedge clk);
        chk("addr", {addr_en, dev_addr}, 8'h00);
        tokchk(7'h05, 2'h0, `UEMC_KIND_SETUP, 3'h0);
    endtask
    // ---------------
    // run control
    // ---------------
    task end_of_test;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        #20000;
        miscompares++;
        end_of_test;
    end
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset;
        t_addr;
        t_modes;
        t_lock;
        t_setup;
        end_of_test;
    end
endmodule
